// ### rtl/cpsc_pkg.sv
// Constants, types and register map of the clock prescaler and sleep control.
// Assumes one master clock; all slower clocks leave the block as enable pulses.
package cpsc_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_DIVCTL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_SLEEPCTL = 4'h1;

    // Divide control fields
    localparam int DIV_UNLOCK_BIT = 7;
    localparam int DIV_SEL_LSB = 0;
    localparam int DIV_SEL_W = 4;
    localparam logic [DATA_W-1:0] DIV_UNLOCK_WORD = 8'h80;
    localparam logic [DIV_SEL_W-1:0] SEL_DIV1 = 4'h0;
    localparam logic [DIV_SEL_W-1:0] SEL_DIV8 = 4'h3;
    localparam logic [DIV_SEL_W-1:0] SEL_MAX = 4'h8;

    // Sleep control fields
    localparam int SLP_PULLUP_BIT = 6;
    localparam int SLP_ALLOW_BIT = 5;
    localparam int SLP_KIND_LSB = 3;
    localparam int SLP_SENSE_LSB = 0;
    localparam logic [DATA_W-1:0] SLEEPCTL_RESET = 8'h00;

    // Sleep kinds
    localparam logic [1:0] SK_IDLE = 2'h0;
    localparam logic [1:0] SK_ADCNR = 2'h1;
    localparam logic [1:0] SK_PDOWN = 2'h2;
    localparam logic [1:0] SK_RSVD = 2'h3;

    // Timing counts
    localparam int CNT_W = 8;
    localparam int UNLOCK_CYC = 4;
    localparam int HOLD_CYC = 4;
    localparam int STARTUP_CK = 6;
    localparam logic [2:0] UNLOCK_LAST = 3'(UNLOCK_CYC - 1);
    localparam logic [2:0] HOLD_LAST = 3'(HOLD_CYC - 1);
    localparam logic [2:0] STARTUP_LAST = 3'(STARTUP_CK - 1);

    typedef enum logic [1:0] {
        PM_RUN = 2'b00,
        PM_SLEEP = 2'b01,
        PM_START = 2'b11,
        PM_HOLD = 2'b10
    } cpsc_pm_t;

    typedef struct packed {
        logic anyIrq;
        logic adcDone;
        logic storeReady;
        logic extLevel;
        logic pinChange;
        logic wdtIrq;
    } cpsc_wake_t;

    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
        logic osc;
    } cpsc_clken_t;

endpackage : cpsc_pkg

// ### rtl/cpsc_top.sv
// Clock prescaler with timed unlock, and three-mode sleep control.
// Assumes bus strobes and the sleep instruction pulse arrive in CPU-enabled cycles.
//
// How it works
// - One division factor drives CPU, flash, I/O and converter enables alike.
// - Unlock bit sets only when the write is exactly 0x80.
// - Unlock clears after four cycles or when the select field is written.
// - Rewriting unlock while open neither restarts nor cancels the window.
// - Reserved bits of both registers read as zero.
// - Select codes 0..8 give divide by 1..256; 9..15 are reserved.
// - Reset loads select 0000, or 0011 when the div8 fuse is programmed.
// - Any select value is accepted through unlock, whatever the fuse.
// - Division changes only on an old-period boundary, so no glitch.
// - New rate is active one old plus one new period after the write.
// - Prescaler is a master-rate counter and its count is never readable.
// - Sleep instruction sleeps only while the sleep allow bit is one.
// - Sleep kind 00 idle, 01 converter quiet, 10 power-down, 11 reserved.
// - On wake the CPU is held four cycles beyond start-up.
// - State survives sleep; reset during sleep returns to running.
// - Idle stops CPU and flash only; wakes on any enabled interrupt.
// - Idle or converter quiet entry starts a conversion if enabled.
// - Converter quiet stops I/O, CPU, flash; limited wake sources.
// - Power-down stops oscillator and all clocks; fewest wake sources.
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module cpsc_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [cpsc_pkg::ADDR_W-1:0] regAddr,
    input wire logic [cpsc_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [cpsc_pkg::DATA_W-1:0] regRdData,
    input wire logic initialDiv8FuseProg,
    input wire logic sleepInstr,
    input wire logic adcEnabled,
    input wire cpsc_pkg::cpsc_wake_t wakeReq,
    output cpsc_pkg::cpsc_clken_t clkEn,
    output logic adcStartConv,
    output logic cpuHalted,
    output logic pullupGlobalOff,
    output logic [1:0] extIrqSense
);
    import cpsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic fuseDone;
        logic [DIV_SEL_W-1:0] sel;
        logic pend;
        logic [DIV_SEL_W-1:0] pendSel;
        logic [CNT_W-1:0] cnt;
        logic unlock;
        logic [2:0] unlockCnt;
        logic sleepAllow;
        logic [1:0] kind;
        logic pullupOff;
        logic [1:0] sense;
        cpsc_pm_t mode;
        logic [1:0] curKind;
        logic [2:0] wcnt;
        logic halted;
        cpsc_clken_t en;
        logic adcStart;
        logic [DATA_W-1:0] rdata;
    } cpsc_state_t;

    cpsc_state_t s;
    cpsc_state_t next_s;

    // Reserved codes saturate at the largest factor rather than run fast
    function automatic logic [CNT_W-1:0] divMask(input logic [DIV_SEL_W-1:0] sel);
        logic [DIV_SEL_W-1:0] k;
        k = (sel > SEL_MAX) ? SEL_MAX : sel;
        divMask = CNT_W'((9'h001 << k) - 9'h001);
    endfunction : divMask

    function automatic logic wakeHit(input logic [1:0] kind, input cpsc_wake_t w);
        unique case (kind)
            SK_IDLE: wakeHit = |w;
            SK_ADCNR: wakeHit = w.adcDone | w.storeReady | w.extLevel | w.pinChange | w.wdtIrq;
            SK_PDOWN: wakeHit = w.extLevel | w.pinChange | w.wdtIrq;
            default: wakeHit = 1'b1;
        endcase
    endfunction : wakeHit

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic oscRun;
        logic tick;
        logic cpuTick;
        logic asleep;
        logic [CNT_W-1:0] m;
        oscRun = 1'b0;
        tick = 1'b0;
        cpuTick = 1'b0;
        asleep = 1'b0;
        m = '0;
        next_s = s;
        next_s.adcStart = 1'b0;
        next_s.rdata = '0;

        // Fuse strap caught after reset release
        if (!s.fuseDone) begin
            next_s.fuseDone = 1'b1;
            next_s.sel = initialDiv8FuseProg ? SEL_DIV8 : SEL_DIV1;
        end

        oscRun = !(s.mode == PM_SLEEP && s.curKind == SK_PDOWN);
        asleep = (s.mode != PM_RUN);

        m = divMask(s.sel);
        tick = oscRun && s.fuseDone && ((s.cnt & m) == m);
        cpuTick = tick && !asleep;
        if (oscRun) begin
            // Switch only on an old-period edge; restart count
            if (tick && s.pend) begin
                next_s.sel = s.pendSel;
                next_s.pend = 1'b0;
                next_s.cnt = '0;
            end else begin
                next_s.cnt = s.cnt + 8'h01;
            end
        end

        // Window counted in CPU cycles; timeout
        if (s.unlock && cpuTick) begin
            if (s.unlockCnt == UNLOCK_LAST) begin
                next_s.unlock = 1'b0;
                next_s.unlockCnt = '0;
            end else begin
                next_s.unlockCnt = s.unlockCnt + 3'h1;
            end
        end

        if (regWr && regAddr == ADDR_DIVCTL) begin
            if (regWrData == DIV_UNLOCK_WORD) begin
                // Exact unlock word; open window left alone
                if (!s.unlock) begin
                    next_s.unlock = 1'b1;
                    next_s.unlockCnt = '0;
                end
            end else if (s.unlock && !regWrData[DIV_UNLOCK_BIT]) begin
                // Any code accepted; select write closes window
                next_s.pend = 1'b1;
                next_s.pendSel = regWrData[DIV_SEL_LSB +: DIV_SEL_W];
                next_s.unlock = 1'b0;
                next_s.unlockCnt = '0;
            end
        end
        if (regWr && regAddr == ADDR_SLEEPCTL) begin
            next_s.pullupOff = regWrData[SLP_PULLUP_BIT];
            next_s.sleepAllow = regWrData[SLP_ALLOW_BIT];
            next_s.kind = regWrData[SLP_KIND_LSB +: 2];
            next_s.sense = regWrData[SLP_SENSE_LSB +: 2];
        end

        // Reserved bits and unmapped addresses read zero
        if (regRd) begin
            if (regAddr == ADDR_DIVCTL) begin
                next_s.rdata[DIV_UNLOCK_BIT] = s.unlock;
                next_s.rdata[DIV_SEL_LSB +: DIV_SEL_W] = s.sel;
            end else if (regAddr == ADDR_SLEEPCTL) begin
                next_s.rdata[SLP_PULLUP_BIT] = s.pullupOff;
                next_s.rdata[SLP_ALLOW_BIT] = s.sleepAllow;
                next_s.rdata[SLP_KIND_LSB +: 2] = s.kind;
                next_s.rdata[SLP_SENSE_LSB +: 2] = s.sense;
            end
        end

        // Nothing is cleared by sleep; a wake through hold or a reset returns to run
        unique case (s.mode)
            PM_RUN: begin
                // Allow bit gates; reserved kind does not sleep
                if (sleepInstr && s.sleepAllow && s.kind != SK_RSVD) begin
                    next_s.mode = PM_SLEEP;
                    next_s.curKind = s.kind;
                    next_s.adcStart = adcEnabled && (s.kind != SK_PDOWN);
                end
            end
            PM_SLEEP: begin
                if (wakeHit(s.curKind, wakeReq)) begin
                    next_s.mode = (s.curKind == SK_PDOWN) ? PM_START : PM_HOLD;
                    next_s.wcnt = '0;
                end
            end
            PM_START: begin
                if (s.wcnt == STARTUP_LAST) begin
                    next_s.mode = PM_HOLD;
                    next_s.wcnt = '0;
                end else begin
                    next_s.wcnt = s.wcnt + 3'h1;
                end
            end
            PM_HOLD: begin
                // Four CPU cycles of hold after start-up
                if (tick) begin
                    if (s.wcnt == HOLD_LAST) begin
                        next_s.mode = PM_RUN;
                        next_s.wcnt = '0;
                    end else begin
                        next_s.wcnt = s.wcnt + 3'h1;
                    end
                end
            end
        endcase

        // Same tick feeds every domain; gating by kind
        next_s.en.cpu = cpuTick;
        next_s.en.flash = cpuTick;
        next_s.en.io = tick && !(asleep && s.curKind != SK_IDLE);
        next_s.en.adc = tick && !(asleep && s.curKind == SK_PDOWN);
        next_s.en.osc = oscRun;
        // Halt flag registered so the port comes from a flop
        next_s.halted = (next_s.mode != PM_RUN);
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.sleepAllow <= SLEEPCTL_RESET[SLP_ALLOW_BIT];
            s.mode <= PM_RUN;
        end else begin
            s <= next_s;
        end
    end

    assign regRdData = s.rdata;
    assign clkEn = s.en;
    assign adcStartConv = s.adcStart;
    assign cpuHalted = s.halted;
    assign pullupGlobalOff = s.pullupOff;
    assign extIrqSense = s.sense;

endmodule : cpsc_top

`default_nettype wire

// ### testbench/cpsc_cpu_model.sv
// CPU-side partner: drives register strobes and the sleep pulse.
// Assumes it shares core_clk and sees the CPU enable of the block.
`timescale 1ns/1ps
`default_nettype none
module cpsc_cpu_model (
    input wire logic core_clk,
    input wire logic cpuEn,
    input wire logic [cpsc_pkg::DATA_W-1:0] regRdData,
    output logic [cpsc_pkg::ADDR_W-1:0] regAddr,
    output logic [cpsc_pkg::DATA_W-1:0] regWrData,
    output logic regWr,
    output logic regRd,
    output logic sleepInstr
);
    import cpsc_pkg::*;
    initial begin
        {regAddr, regWrData, regWr, regRd, sleepInstr} = '0;
    end
    // Kind 0 write, 1 read, 2 sleep; one strobe cycle after a CPU cycle
    task automatic acc(input int k, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
        output logic [DATA_W-1:0] q, output logic late);
        int n;
        logic e;
        n = 0;
        do begin
            @(negedge core_clk);
            e = cpuEn;
            n++;
        end while (!e && n < 600);
        late = (n >= 600);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= (k == 0);
        regRd <= (k == 1);
        sleepInstr <= (k == 2);
        @(posedge core_clk);
        regWr <= 1'b0;
        regRd <= 1'b0;
        sleepInstr <= 1'b0;
        // Data no longer qualified, so it is not left looking valid
        regWrData <= ~d;
        #1 q = regRdData;
    endtask : acc
endmodule : cpsc_cpu_model
`default_nettype wire

// ### testbench/cpsc_chk.sv
// Port-level assertions for the prescaler and sleep control.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module cpsc_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [cpsc_pkg::ADDR_W-1:0] regAddr,
    input wire logic regRd,
    input wire logic [cpsc_pkg::DATA_W-1:0] regRdData,
    input wire logic sleepInstr,
    input wire logic adcEnabled,
    input wire cpsc_pkg::cpsc_clken_t clkEn,
    input wire logic adcStartConv,
    input wire logic cpuHalted
);
    import cpsc_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_enter;
        sleepInstr ##1 cpuHalted;
    endsequence
    AST_DIV_RSV: assert property ($past(regRd) && $past(regAddr) == ADDR_DIVCTL |-> regRdData[6:4] == 3'h0)
        else $error("divide reserved bits set");
    AST_SLP_RSV: assert property ($past(regRd) && $past(regAddr) == ADDR_SLEEPCTL |-> !regRdData[7] && !regRdData[2])
        else $error("sleep reserved bits set");
    AST_RD_IDLE: assert property (!$past(regRd) |-> regRdData == 8'h00)
        else $error("read data outside its cycle");
    AST_SLEEP_CAUSE: assert property ($rose(cpuHalted) |-> $past(sleepInstr))
        else $error("halt without sleep instruction");
    AST_HOLD_MIN: assert property (s_enter |=> cpuHalted[*4])
        else $error("wake hold too short");
    AST_CLK_SAME: assert property (!cpuHalted && !$past(cpuHalted) && !$past(cpuHalted, 2)
        |-> clkEn.io == clkEn.cpu && clkEn.adc == clkEn.cpu && clkEn.flash == clkEn.cpu)
        else $error("domains divided unequally");
    AST_CPU_STOP: assert property (cpuHalted && $past(cpuHalted) |-> !clkEn.cpu && !clkEn.flash)
        else $error("cpu clock while halted");
    AST_CONV_START: assert property (adcStartConv |-> $rose(cpuHalted) && $past(adcEnabled))
        else $error("conversion start without sleep entry");
    AST_OSC_OFF: assert property (!clkEn.osc |-> clkEn[4:1] == 4'h0)
        else $error("clock without oscillator");
endmodule : cpsc_chk
bind cpsc_top cpsc_chk i_cpsc_chk (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regRd(regRd),
    .regRdData(regRdData), .sleepInstr(sleepInstr), .adcEnabled(adcEnabled), .clkEn(clkEn),
    .adcStartConv(adcStartConv), .cpuHalted(cpuHalted));
`default_nettype wire

// ### testbench/clock_prescaler_sleep_control_tb.sv
// Self-checking bench: reset values, unlock window, division, sleep.
// Assumes the CPU partner model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module clock_prescaler_sleep_control_tb;
    import cpsc_pkg::*;
    logic core_clk, rst_n, fuse, adcEn, halted, conv, pullOff, wr, rd, slp, late;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, q, d;
    logic [1:0] sense;
    logic [16:0] rnd;
    cpsc_wake_t wake;
    cpsc_clken_t clkEn, seen;
    int totalChecks, nMismatch, n;
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    cpsc_top i_cpsc_top (.core_clk(core_clk), .rst_n(rst_n), .regAddr(addr), .regWrData(wdata), .regWr(wr),
        .regRd(rd), .regRdData(rdata), .initialDiv8FuseProg(fuse), .sleepInstr(slp), .adcEnabled(adcEn),
        .wakeReq(wake), .clkEn(clkEn), .adcStartConv(conv), .cpuHalted(halted), .pullupGlobalOff(pullOff),
        .extIrqSense(sense));
    cpsc_cpu_model i_cpsc_cpu_model (.core_clk(core_clk), .cpuEn(clkEn.cpu), .regRdData(rdata), .regAddr(addr),
        .regWrData(wdata), .regWr(wr), .regRd(rd), .sleepInstr(slp));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [16:0] lfsr(input logic [16:0] x);
        return {x[15:0], x[16] ^ x[13]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [7:0] sv, input logic [7:0] ev);
        totalChecks++;
        if (sv !== ev) begin
            nMismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, ev, sv);
        end
    endtask : chk
    task automatic completeRun;
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : completeRun
    task automatic acc(input int k, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        i_cpsc_cpu_model.acc(k, a, v, q, late);
        if (late) begin
            nMismatch++;
            completeRun();
        end
    endtask : acc
    task automatic doReset(input logic f);
        rst_n <= 1'b0;
        fuse <= f;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask : doReset
    // Cycles until the next CPU enable, bounded
    task automatic gap(output int c);
        c = 0;
        do begin
            @(negedge core_clk);
            c++;
        end while (!clkEn.cpu && c < 600);
        if (c >= 600) begin
            nMismatch++;
            completeRun();
        end
    endtask : gap
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, fuse, adcEn, wake} = '0;
        rnd = 17'h1_6754;
        totalChecks = 0;
        nMismatch = 0;
        doReset(1'b1);
        acc(1, ADDR_DIVCTL, 8'h00);
        chk("div fuse", q, {4'h0, SEL_DIV8});
        doReset(1'b0);
        acc(1, ADDR_DIVCTL, 8'h00);
        chk("div reset", q, {4'h0, SEL_DIV1});
        acc(1, ADDR_SLEEPCTL, 8'h00);
        chk("slp reset", q, SLEEPCTL_RESET);
        acc(0, 4'h5, 8'hFF);
        acc(1, 4'h5, 8'h00);
        chk("unmapped", q, 8'h00);
        acc(0, ADDR_DIVCTL, 8'h81);
        acc(1, ADDR_DIVCTL, 8'h00);
        chk("unlock dirty", q, 8'h00);
        acc(0, ADDR_DIVCTL, DIV_UNLOCK_WORD);
        acc(1, ADDR_DIVCTL, 8'h00);
        chk("unlock open", q, DIV_UNLOCK_WORD);
        repeat (6) @(posedge core_clk);
        acc(1, ADDR_DIVCTL, 8'h00);
        chk("unlock expire", q, 8'h00);
        repeat (2) acc(0, ADDR_DIVCTL, DIV_UNLOCK_WORD);
        acc(1, ADDR_DIVCTL, 8'h00);
        chk("unlock kept", q, DIV_UNLOCK_WORD);
        acc(1, ADDR_DIVCTL, 8'h00);
        chk("unlock rewrite", q, 8'h00);
        $display("test unlock done");
        for (int s = 0; s < 16; s++) begin
            doReset(s[0]);
            // Back to back, nothing may slip in between
            acc(0, ADDR_DIVCTL, DIV_UNLOCK_WORD);
            acc(0, ADDR_DIVCTL, 8'(s));
            gap(n);
            gap(n);
            gap(n);
            chk("period", 8'(n - 1), 8'(((s > SEL_MAX) ? 256 : (1 << s)) - 1));
            acc(1, ADDR_DIVCTL, 8'h00);
            chk("div sel", q, {4'h0, 4'(s)});
        end
        $display("test divide done");
        doReset(1'b0);
        adcEn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            d = {rnd[7:6], 1'b1, 2'(k), rnd[2:0]};
            acc(0, ADDR_SLEEPCTL, d);
            acc(1, ADDR_SLEEPCTL, 8'h00);
            chk("slp read", q, d & 8'h7B);
            chk("pins", {5'h0, pullOff, sense}, {5'h0, d[6], d[1:0]});
            acc(2, 4'h0, 8'h00);
            chk("halted", {7'h0, halted}, {7'h0, 1'(k != 3)});
            chk("conv", {7'h0, conv}, {7'h0, 1'(k < 2)});
            seen = '0;
            // Enables of the entry cycle were launched while still running
            @(posedge core_clk);
            repeat (32) begin
                @(negedge core_clk);
                seen |= clkEn;
            end
            chk("domains", {3'h0, seen}, (k == 0) ? 8'h07 : (k == 1) ? 8'h03 : (k == 2) ? 8'h00 : 8'h1F);
            @(posedge core_clk);
            if (k < 3) begin
                wake <= (k == 0) ? 6'h00 : (k == 1) ? 6'h20 : 6'h38;
                repeat (16) @(posedge core_clk);
                chk("asleep", {7'h0, halted}, 8'h01);
                wake <= 6'h02 | {5'h0, rnd[8]};
                n = 0;
                do begin
                    @(posedge core_clk);
                    n++;
                    #1;
                end while (halted && n < 60);
                chk("wake hold", {7'h0, 1'(n >= ((k == 2) ? 10 : 4))}, 8'h01);
                chk("woken", {7'h0, halted}, 8'h00);
                wake <= '0;
                acc(1, ADDR_SLEEPCTL, 8'h00);
                chk("kept", q, d & 8'h7B);
            end
            acc(0, ADDR_SLEEPCTL, d & 8'hDF);
            acc(2, 4'h0, 8'h00);
            chk("no allow", {7'h0, halted}, 8'h00);
        end
        acc(0, ADDR_SLEEPCTL, 8'h30);
        acc(2, 4'h0, 8'h00);
        doReset(1'b0);
        chk("reset wake", {7'h0, halted}, 8'h00);
        $display("test sleep done");
        completeRun();
    end
endmodule : clock_prescaler_sleep_control_tb
`default_nettype wire
